//--- rtl/ssrg_defines.vh
// constants for the soft start ramp generator: register map, fields, resets, timing
// Summary of operation
// - two ramp parameter sets, chosen by the external set-select contact input.
// - profile 1..4 sets ramp types: V/V, C/C, V/C, C/V for sets one, two.
// - voltage ramp rises from initial voltage to full voltage over ramp time.
// - current limit at its maximum of 600% disables limiting entirely.
// - voltage ramp holds current at limit, resumes rising once current drops below.
// - ramp time fixes slope up to the limit; limiting may lengthen acceleration.
// - current ramp rises linearly from initial current to limit over ramp time.
// - current ramp drives voltage by PI loop on measured motor current.
// - maximum initial level with minimum ramp time steps straight to the limit.
// - ramp starts from the initial voltage or current, never from zero.
// - ramp time is the longest time from initial level to limit or full, save while a voltage ramp is held at the limit.
// - reaching full speed before ramp end cuts the ramp short.
// - current limit caps motor current in both voltage and current ramps.
// - limiting holds until at-speed or overload trip, then becomes inactive.
// - current limit setpoint is never below 200% of motor current.
// - no time-out at current limit; only overload, at-speed or a cleared start ends a long start.
`ifndef SSRG_DEFINES_VH
`define SSRG_DEFINES_VH

// register byte offsets
`define SSRG_A_CTRL      8'h00
`define SSRG_A_PROFILE   8'h04
`define SSRG_A_S1_IV     8'h08
`define SSRG_A_S1_IC     8'h0C
`define SSRG_A_S1_RT     8'h10
`define SSRG_A_S1_CL     8'h14
`define SSRG_A_S2_IV     8'h18
`define SSRG_A_S2_IC     8'h1C
`define SSRG_A_S2_RT     8'h20
`define SSRG_A_S2_CL     8'h24
`define SSRG_A_STATUS    8'h28
`define SSRG_A_VOUT      8'h2C
`define SSRG_A_GAINS     8'h30

// control and status fields
`define SSRG_CTRL_START  0
`define SSRG_ST_RUN      0
`define SSRG_ST_LIMIT    1
`define SSRG_ST_DONE     2
`define SSRG_ST_TRIP     3
`define SSRG_ST_SET2     4
`define SSRG_ST_CRAMP    5

// levels: voltage in 0.1 % of line, current in % of motor current
`define SSRG_V_FULL      16'h03E8
`define SSRG_CL_MIN      16'h00C8
`define SSRG_CL_MAX      16'h0258

// reset values
`define SSRG_RST_PROFILE 3'h1
`define SSRG_RST_IV      16'h0190
`define SSRG_RST_IC      16'h00C8
`define SSRG_RST_RT      16'h000A
`define SSRG_RST_CL      16'h0158
`define SSRG_RST_GAINS   16'h0402

// timing: control tick period in us, ramp time unit in ms
`define SSRG_TICK_US     1000
`define SSRG_CLK_MHZ     10
`define SSRG_TICK_CYC    (`SSRG_TICK_US * `SSRG_CLK_MHZ)
`define SSRG_RT_UNIT_MS  1000
`define SSRG_TICKS_PER_RT (`SSRG_RT_UNIT_MS * 1000 / `SSRG_TICK_US)

`endif

//--- rtl/ssrg_ramp_step.v
// fixed-point stepper that walks a setpoint from a start level toward a target
`timescale 1ns/10ps
`include "ssrg_defines.vh"
module ssrg_ramp_step
#(
   parameter W = 16
)
(
   input  wire         mclk_i,
   input  wire         rst_n_i,
   input  wire         load_i,
   input  wire         tick_i,
   input  wire         hold_i,
   input  wire [W-1:0] start_i,
   input  wire [W-1:0] target_i,
   input  wire [31:0]  ticks_i,
   output wire [W-1:0] level_o,
   output wire         end_o
);
   reg  [W+15:0] acc_q;
   reg  [W+15:0] step_q;
   wire [W+15:0] tgt_w   = {target_i, 16'h0000};
   wire [W+16:0] nxt_w   = {1'b0, acc_q} + {1'b0, step_q};

   // step = span / ticks, fixed once at load; zero ticks means a jump
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         acc_q  <= {(W+16){1'b0}};
         step_q <= {(W+16){1'b0}};
      end
      else if (load_i)
      begin
         acc_q <= {start_i, 16'h0000};
         if (ticks_i == 32'h0000_0000 || target_i <= start_i)
            step_q <= tgt_w;
         else
            step_q <= ({target_i - start_i, 16'h0000}) / ticks_i[W+15:0];
      end
      else if (tick_i && !hold_i)
      begin
         // clamp at target so rounding never overshoots
         if (nxt_w >= {1'b0, tgt_w})
            acc_q <= tgt_w;
         else
            acc_q <= nxt_w[W+15:0];
      end
   end

   assign level_o = acc_q[W+15:16];
   assign end_o   = (acc_q >= tgt_w);
endmodule // ssrg_ramp_step

//--- rtl/ssrg_ramp_gen.v
// soft start ramp generator with ahb-lite register slave
`timescale 1ns/10ps
`include "ssrg_defines.vh"
module ssrg_ramp_gen
#(
   parameter TICK_CYC = `SSRG_TICK_CYC,
   parameter TPR      = `SSRG_TICKS_PER_RT
)
(
   input  wire        mclk_i,
   input  wire        rst_n_i,
   // ahb-lite slave
   input  wire        hsel_i,
   input  wire [7:0]  haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // power stage and motor side
   input  wire        set_select_i,
   input  wire        at_speed_i,
   input  wire        overload_trip_i,
   input  wire [15:0] motor_current_i,
   output wire [15:0] voltage_cmd_o,
   output wire [15:0] current_ref_o,
   output wire        ramp_active_o,
   output wire        current_limit_active_o,
   output wire        ramp_done_o
);
   localparam S_IDLE = 2'h0;
   localparam S_RAMP = 2'h1;
   localparam S_DONE = 2'h2;
   localparam S_TRIP = 2'h3;

   // clamp limit into its legal band on write
   function [15:0] clamp_cl;
      input [31:0] v;
      begin
         if (v[15:0] < `SSRG_CL_MIN)
            clamp_cl = `SSRG_CL_MIN;
         else if (v[15:0] > `SSRG_CL_MAX)
            clamp_cl = `SSRG_CL_MAX;
         else
            clamp_cl = v[15:0];
      end
   endfunction

   // profile to ramp type: 1 = current ramp
   function ramp_is_cur;
      input [2:0] p;
      input       set2;
      begin
         case (p)
            3'h2:    ramp_is_cur = 1'b1;
            3'h3:    ramp_is_cur = set2;
            3'h4:    ramp_is_cur = ~set2;
            default: ramp_is_cur = 1'b0;
         endcase
      end
   endfunction

   reg [2:0]  profile_q;
   reg [15:0] s1_iv_q, s1_ic_q, s1_rt_q, s1_cl_q;
   reg [15:0] s2_iv_q, s2_ic_q, s2_rt_q, s2_cl_q;
   reg [15:0] gains_q;
   reg        start_q;
   reg [1:0]  state_q;
   reg        set2_q;
   reg        cramp_q;
   reg [15:0] vout_q;
   reg [15:0] iref_q;
   reg        limit_q;
   reg [15:0] tick_cnt_q;
   reg        tick_q;
   reg        load_q;
   reg        dph_q;
   reg        dwr_q;
   reg [7:0]  daddr_q;
   reg [31:0] rdata_q;
   reg signed [19:0] integ_q;
   reg [31:0] rd_d;

   // active set is latched at start so a contact change mid-ramp has no effect
   wire        set2_w  = set2_q;
   wire [15:0] iv_w    = set2_w ? s2_iv_q : s1_iv_q;
   wire [15:0] ic_w    = set2_w ? s2_ic_q : s1_ic_q;
   wire [15:0] rt_w    = set2_w ? s2_rt_q : s1_rt_q;
   wire [15:0] cl_w    = set2_w ? s2_cl_q : s1_cl_q;
   wire        no_lim_w = (cl_w >= `SSRG_CL_MAX);
   wire [31:0] ticks_w = rt_w * TPR;
   wire [15:0] st_lvl_w = cramp_q ? ic_w : iv_w;
   wire [15:0] tg_lvl_w = cramp_q ? cl_w : `SSRG_V_FULL;
   wire        over_w  = !no_lim_w && (motor_current_i >= cl_w);
   wire [15:0] ramp_lvl_w;
   wire        ramp_end_w;

   // voltage ramp pauses while current sits at limit, slope kept
   ssrg_ramp_step #(.W(16)) u_step
   (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (load_q),
      .tick_i  (tick_q),
      .hold_i  (!cramp_q && over_w),
      .start_i (st_lvl_w),
      .target_i(tg_lvl_w),
      .ticks_i (ticks_w),
      .level_o (ramp_lvl_w),
      .end_o   (ramp_end_w)
   );

   // ahb-lite: zero wait states, always okay
   wire addr_ok_w = hsel_i && hready_i && htrans_i[1];
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dph_q   <= 1'b0;
         dwr_q   <= 1'b0;
         daddr_q <= 8'h00;
      end
      else if (hready_i)
      begin
         dph_q   <= addr_ok_w;
         dwr_q   <= addr_ok_w && hwrite_i;
         daddr_q <= haddr_i;
      end
   end

   // read mux; unmapped offsets read zero
   always @*
   begin
      rd_d = 32'h0000_0000;
      case (haddr_i)
         `SSRG_A_CTRL:    rd_d = {31'h0000_0000, start_q};
         `SSRG_A_PROFILE: rd_d = {29'h0000_0000, profile_q};
         `SSRG_A_S1_IV:   rd_d = {16'h0000, s1_iv_q};
         `SSRG_A_S1_IC:   rd_d = {16'h0000, s1_ic_q};
         `SSRG_A_S1_RT:   rd_d = {16'h0000, s1_rt_q};
         `SSRG_A_S1_CL:   rd_d = {16'h0000, s1_cl_q};
         `SSRG_A_S2_IV:   rd_d = {16'h0000, s2_iv_q};
         `SSRG_A_S2_IC:   rd_d = {16'h0000, s2_ic_q};
         `SSRG_A_S2_RT:   rd_d = {16'h0000, s2_rt_q};
         `SSRG_A_S2_CL:   rd_d = {16'h0000, s2_cl_q};
         `SSRG_A_STATUS:  rd_d = {26'h000_0000, cramp_q, set2_q, state_q == S_TRIP,
                                  state_q == S_DONE, limit_q, state_q == S_RAMP};
         `SSRG_A_VOUT:    rd_d = {iref_q, vout_q};
         `SSRG_A_GAINS:   rd_d = {16'h0000, gains_q};
         default:         rd_d = 32'h0000_0000;
      endcase
   end

   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_q <= 32'h0000_0000;
      else if (addr_ok_w && !hwrite_i)
         rdata_q <= rd_d;
   end

   // register writes in the data phase
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         start_q   <= 1'b0;
         profile_q <= `SSRG_RST_PROFILE;
         s1_iv_q   <= `SSRG_RST_IV;
         s1_ic_q   <= `SSRG_RST_IC;
         s1_rt_q   <= `SSRG_RST_RT;
         s1_cl_q   <= `SSRG_RST_CL;
         s2_iv_q   <= `SSRG_RST_IV;
         s2_ic_q   <= `SSRG_RST_IC;
         s2_rt_q   <= `SSRG_RST_RT;
         s2_cl_q   <= `SSRG_RST_CL;
         gains_q   <= `SSRG_RST_GAINS;
      end
      else if (dwr_q)
      begin
         case (daddr_q)
            `SSRG_A_CTRL:    start_q <= hwdata_i[`SSRG_CTRL_START];
            `SSRG_A_PROFILE:
               if (hwdata_i[2:0] >= 3'h1 && hwdata_i[2:0] <= 3'h4)
                  profile_q <= hwdata_i[2:0];
            `SSRG_A_S1_IV:   s1_iv_q <= (hwdata_i[15:0] > `SSRG_V_FULL) ? `SSRG_V_FULL : hwdata_i[15:0];
            `SSRG_A_S1_IC:   s1_ic_q <= hwdata_i[15:0];
            `SSRG_A_S1_RT:   s1_rt_q <= hwdata_i[15:0];
            `SSRG_A_S1_CL:   s1_cl_q <= clamp_cl(hwdata_i);
            `SSRG_A_S2_IV:   s2_iv_q <= (hwdata_i[15:0] > `SSRG_V_FULL) ? `SSRG_V_FULL : hwdata_i[15:0];
            `SSRG_A_S2_IC:   s2_ic_q <= hwdata_i[15:0];
            `SSRG_A_S2_RT:   s2_rt_q <= hwdata_i[15:0];
            `SSRG_A_S2_CL:   s2_cl_q <= clamp_cl(hwdata_i);
            `SSRG_A_GAINS:   gains_q <= hwdata_i[15:0];
            default:         start_q <= start_q;
         endcase
      end
   end

   // control tick divider
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q == TICK_CYC[15:0] - 16'h0001)
      begin
         tick_cnt_q <= 16'h0000;
         tick_q     <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q     <= 1'b0;
      end
   end

   // start sequence: no time-out while limiting, only trip, at-speed or a cleared start end it
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= S_IDLE;
         set2_q  <= 1'b0;
         cramp_q <= 1'b0;
         load_q  <= 1'b0;
      end
      else
      begin
         load_q <= 1'b0;
         case (state_q)
            S_IDLE:
               if (start_q)
               begin
                  set2_q  <= set_select_i;
                  cramp_q <= ramp_is_cur(profile_q, set_select_i);
                  load_q  <= 1'b1;
                  state_q <= S_RAMP;
               end
            S_RAMP:
               if (overload_trip_i)
                  state_q <= S_TRIP;
               else if (at_speed_i)
                  state_q <= S_DONE;
               else if (!start_q)
                  state_q <= S_IDLE;
            S_DONE:
               if (!start_q)
                  state_q <= S_IDLE;
            S_TRIP:
               if (!start_q)
                  state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // output loop: voltage ramp follows stepper, current ramp via pi loop
   wire signed [16:0] err_w  = $signed({1'b0, iref_q}) - $signed({1'b0, motor_current_i});
   wire signed [19:0] integ_n_w = integ_q + {{3{err_w[16]}}, err_w};
   // every term kept signed so a negative error pulls the output down
   wire signed [23:0] pid_w  = ($signed({1'b0, gains_q[15:8]}) * err_w) +
                               ($signed({{4{integ_q[19]}}, integ_q}) >>> 2);
   wire signed [23:0] vsum_w = $signed({8'h00, vout_q}) + (pid_w >>> 4);
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         vout_q  <= 16'h0000;
         iref_q  <= 16'h0000;
         limit_q <= 1'b0;
         integ_q <= 20'h00000;
      end
      else if (state_q == S_RAMP && !load_q)                         // stepper still shows last ramp while loading
      begin
         limit_q <= over_w;
         if (!cramp_q)
         begin
            iref_q <= no_lim_w ? `SSRG_CL_MAX : cl_w;
            if (over_w && vout_q != 16'h0000)
               vout_q <= vout_q - 16'h0001;
            else if (!over_w)
               vout_q <= (ramp_lvl_w > vout_q) ? ramp_lvl_w : vout_q;
         end
         else if (tick_q)
         begin
            iref_q <= ramp_lvl_w;
            integ_q <= integ_n_w;
            if (vsum_w < 24'sd0)
               vout_q <= 16'h0000;
            else if (vsum_w > $signed({8'h00, `SSRG_V_FULL}))
               vout_q <= `SSRG_V_FULL;
            else
               vout_q <= vsum_w[15:0];
         end
      end
      else if (state_q == S_DONE)
      begin
         vout_q  <= `SSRG_V_FULL;
         limit_q <= 1'b0;
      end
      else
      begin
         vout_q  <= 16'h0000;
         limit_q <= 1'b0;
         integ_q <= 20'h00000;
      end
   end

   assign hrdata_o              = rdata_q;
   assign hreadyout_o           = 1'b1;
   assign hresp_o               = 1'b0;
   assign voltage_cmd_o         = vout_q;
   assign current_ref_o         = iref_q;
   assign ramp_active_o         = (state_q == S_RAMP);
   assign current_limit_active_o = limit_q;
   assign ramp_done_o           = (state_q == S_DONE);
endmodule // ssrg_ramp_gen

//--- sim/ssrg_ramp_sva.sv
// port checker for the ramp generator
`timescale 1ns/10ps
module ssrg_ramp_sva
(
   input wire        mclk_i,
   input wire        rst_n_i,
   input wire        at_speed_i,
   input wire        overload_trip_i,
   input wire [15:0] voltage_cmd_o,
   input wire [15:0] current_ref_o,
   input wire        ramp_active_o,
   input wire        current_limit_active_o,
   input wire        ramp_done_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   // output levels never pass full scale
   chk_volt_ceiling: assert property (voltage_cmd_o <= 16'h03E8)
      else $error("voltage command above full");
   chk_iref_ceiling: assert property (current_ref_o <= 16'h0258)
      else $error("current reference above top limit");
   // trip wins and drops the output within three clocks
   chk_trip_zero: assert property (ramp_active_o && overload_trip_i |-> ##[1:3]
      (voltage_cmd_o == 16'h0000 && !ramp_active_o)) else $error("trip did not end ramp");
   chk_speed_release: assert property (ramp_active_o && at_speed_i && !overload_trip_i
      |-> ##[1:3] (ramp_done_o && !current_limit_active_o)) else $error("at speed kept limit");
   chk_done_full: assert property (ramp_done_o [*3] |-> voltage_cmd_o == 16'h03E8)
      else $error("done without full voltage");
   chk_start_level: assert property ($rose(ramp_active_o) |-> ##[0:2]
      (voltage_cmd_o != 16'h0000 || current_ref_o != 16'h0000)) else $error("ramp began at zero");
   // no time-out may end a start held at the limit
   chk_no_timeout: assert property (current_limit_active_o && !at_speed_i && !overload_trip_i
      |=> ramp_active_o) else $error("ramp ended while limiting");
   chk_limit_in_ramp: assert property (current_limit_active_o |->
      (ramp_active_o || $past(ramp_active_o))) else $error("limit active outside ramp");
endmodule // ssrg_ramp_sva

bind ssrg_ramp_gen ssrg_ramp_sva chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .at_speed_i(at_speed_i),
   .overload_trip_i(overload_trip_i), .voltage_cmd_o(voltage_cmd_o), .current_ref_o(current_ref_o),
   .ramp_active_o(ramp_active_o), .current_limit_active_o(current_limit_active_o),
   .ramp_done_o(ramp_done_o));

//--- sim/ssrg_motor_model.sv
// power stage and motor: current follows the voltage command, speed and trip on demand
`timescale 1ns/10ps
module ssrg_motor_model
(
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire [15:0] voltage_cmd_i,
   input  wire [1:0]  load_i,
   input  wire        speed_i,
   input  wire        trip_i,
   output reg  [15:0] motor_current_o,
   output reg         at_speed_o,
   output reg         overload_trip_o
);
   // one clock of lag, so the limit loop sees a real delay; light load shifts current down
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         motor_current_o <= 16'h0000;
         at_speed_o      <= 1'b0;
         overload_trip_o <= 1'b0;
      end
      else
      begin
         motor_current_o <= voltage_cmd_i >> load_i;
         at_speed_o      <= speed_i;
         overload_trip_o <= trip_i;
      end
   end
endmodule // ssrg_motor_model

//--- sim/tb_soft_start_ramp_generator.sv
// self-checking bench for the soft start ramp generator
`timescale 1ns/10ps
module tb_soft_start_ramp_generator;
   logic        mclk_i, rst_n_i, hsel, hwrite, sel, spd, trp;
   logic [1:0]  htrans, load;
   logic [7:0]  haddr;
   logic [31:0] hwdata, rd;
   wire  [31:0] hrdata;
   wire         hrdy, hresp, at_spd, ovl, act, lim, done;
   wire  [15:0] vcmd, iref, icur;
   int          n_mismatch, check_count, cyc;
   // profile, set select, expected current-ramp flag
   logic [4:0]  rows [8] = '{5'h04, 5'h06, 5'h09, 5'h0B, 5'h0C, 5'h0F, 5'h11, 5'h12};
   // address, reset value; last row is unmapped
   logic [39:0] rv [7] = '{40'h0400000001, 40'h0800000190, 40'h0C000000C8, 40'h100000000A,
                           40'h1400000158, 40'h3000000402, 40'h3C00000000};

   ssrg_ramp_gen #(.TICK_CYC(10), .TPR(4)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .set_select_i(sel),
      .at_speed_i(at_spd), .overload_trip_i(ovl), .motor_current_i(icur), .voltage_cmd_o(vcmd),
      .current_ref_o(iref), .ramp_active_o(act), .current_limit_active_o(lim), .ramp_done_o(done));
   ssrg_motor_model motor (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .voltage_cmd_i(vcmd), .load_i(load),
      .speed_i(spd), .trip_i(trp), .motor_current_o(icur), .at_speed_o(at_spd), .overload_trip_o(ovl));

   always #50 mclk_i = ~mclk_i;
   // hang guard, well above the several hundred clocks the tests need
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // single word transfer; address phase held until hready, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge mclk_i); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge mclk_i); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic wait_act;
      for (int i = 0; i < 10 && act !== 1'b1; i++) @(posedge mclk_i);
      chk(act, 1'b1);
   endtask
   // at speed always ends a ramp cleanly before the next test
   task automatic end_ramp(input string s);
      spd <= 1'b1;
      cw(4);
      chk(done, 1'b1);
      chk(lim, 1'b0);
      chk(vcmd, 16'h03E8);
      xfer(1'b1, 8'h00, 32'h0);
      spd <= 1'b0;
      $display("test %s ended, mismatches %0d", s, n_mismatch);
   endtask

   initial
   begin
      {mclk_i, rst_n_i, hsel, hwrite, sel, spd, trp} = 7'h00;
      {htrans, load, haddr, hwdata, n_mismatch, check_count, cyc} = '0;
      cw(5);
      rst_n_i <= 1'b1;
      foreach (rv[i]) rc(rv[i][39:32], rv[i][31:0]);
      chk(hresp, 1'b0);
      // light load keeps current far below any limit, so status shows no limiting
      load <= 2'h3;
      // each profile with each set; select flips mid-ramp and must be ignored
      foreach (rows[i])
      begin
         sel <= rows[i][1];
         xfer(1'b1, 8'h04, {29'h0, rows[i][4:2]});
         xfer(1'b1, 8'h00, 32'h1);
         wait_act();
         sel <= ~rows[i][1];
         rc(8'h28, {26'h0, rows[i][0], rows[i][1], 4'h1});
         end_ramp("profile");
      end
      // out-of-range writes are clamped or dropped
      xfer(1'b1, 8'h14, 32'h64);
      rc(8'h14, 32'hC8);
      xfer(1'b1, 8'h14, 32'h2BC);
      rc(8'h14, 32'h258);
      xfer(1'b1, 8'h04, 32'h5);
      rc(8'h04, 32'h4);
      xfer(1'b1, 8'h08, 32'h7D0);
      rc(8'h08, 32'h3E8);
      // plain voltage ramp, limit at top, heavy load
      xfer(1'b1, 8'h04, 32'h1);
      xfer(1'b1, 8'h08, 32'h190);
      xfer(1'b1, 8'h10, 32'h1);
      sel <= 1'b0;
      load <= 2'h0;
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      cw(2);
      chk(vcmd >= 16'h0190 && vcmd <= 16'h0226, 1'b1);
      cw(80);
      chk(vcmd, 16'h03E8);
      chk(lim, 1'b0);
      end_ramp("voltage");
      // early at speed cuts the ramp short
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      cw(10);
      end_ramp("early speed");
      // limit at 200: voltage holds, then resumes once load falls, then trip
      xfer(1'b1, 8'h14, 32'hC8);
      load <= 2'h2;
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      cw(150);
      chk(vcmd < 16'h03E8, 1'b1);
      chk(lim, 1'b1);
      chk(act, 1'b1);
      load <= 2'h3;
      cw(80);
      chk(vcmd, 16'h03E8);
      trp <= 1'b1;
      cw(4);
      chk(vcmd, 16'h0000);
      chk(act, 1'b0);
      xfer(1'b1, 8'h00, 32'h0);
      trp <= 1'b0;
      $display("test limit ended, mismatches %0d", n_mismatch);
      // current ramp, then a current step and a voltage step
      load <= 2'h0;
      xfer(1'b1, 8'h04, 32'h2);
      xfer(1'b1, 8'h14, 32'h258);
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      // reference follows the stepper only on ticks; wait past the first one
      cw(12);
      chk(iref >= 16'h00C8 && iref <= 16'h015E, 1'b1);
      cw(80);
      chk(iref, 16'h0258);
      chk(vcmd != 16'h0000, 1'b1);
      end_ramp("current");
      xfer(1'b1, 8'h10, 32'h0);
      xfer(1'b1, 8'h14, 32'h190);
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      cw(25);
      chk(iref, 16'h0190);
      end_ramp("current step");
      load <= 2'h2;
      xfer(1'b1, 8'h04, 32'h1);
      xfer(1'b1, 8'h08, 32'h3E8);
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      cw(2);
      chk(vcmd, 16'h03E8);
      end_ramp("voltage step");
      // reset in mid ramp clears outputs and registers
      xfer(1'b1, 8'h00, 32'h1);
      wait_act();
      rst_n_i <= 1'b0;
      cw(2);
      chk({act, lim, done, vcmd}, 19'h0);
      chk(hrdy, 1'b1);
      rst_n_i <= 1'b1;
      rc(8'h08, 32'h190);
      $display("test reset ended, mismatches %0d", n_mismatch);
      stop_test();
   end
endmodule // tb_soft_start_ramp_generator
